// [hw/slvm_pkg.sv]
// slvm_pkg: shared constants of the supply low-voltage monitor
// assumes: imported by slvm_top and tb_top via import slvm_pkg::*; slvm_sync and slvm_delay do not use it
`default_nettype none

package slvm_pkg;

    // register byte addresses on apb
    localparam logic [11:0] ADDR_LOW_VOLTAGE_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_IRQ_CONTROL = 12'h004;

    // low_voltage_control field positions
    localparam int POS_STATUS_FLAG = 5;
    localparam int POS_DETECTOR_ENABLE = 4;
    localparam int POS_BANDGAP_BUFFER_ENABLE = 3;
    localparam int POS_THRESHOLD_SELECT = 0;
    localparam int THRESHOLD_SELECT_WIDTH = 3;

    // irq_control field positions
    localparam int POS_IRQ_FLAG = 0;
    localparam int POS_IRQ_ENABLE = 1;
    localparam int POS_GLOBAL_IRQ_ENABLE = 2;
    localparam int POS_MULTIFUNCTION_GROUP_ENABLE = 3;

    // reset values
    localparam logic [4:0] RESET_CONTROL_BITS = 5'h00;
    localparam logic [3:0] RESET_IRQ_BITS = 4'h0;

    // threshold select codes
    localparam logic [2:0] THRESHOLD_LOW = 3'h5;
    localparam logic [2:0] THRESHOLD_MID = 3'h6;
    localparam logic [2:0] THRESHOLD_HIGH = 3'h7;

    // one-hot threshold choice towards the comparator
    localparam int TAP_LOW = 0;
    localparam int TAP_MID = 1;
    localparam int TAP_HIGH = 2;

    // clock and irq assert delay
    localparam int CLOCK_PERIOD_PS = 8000;
    localparam int IRQ_ASSERT_DELAY_NS = 1000;
    localparam int IRQ_ASSERT_DELAY_CYCLES =
        (IRQ_ASSERT_DELAY_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

endpackage

`default_nettype wire

// [hw/slvm_sync.sv]
// slvm_sync: two flip-flop synchroniser for asynchronous levels
// assumes: pclk domain, clock enable freezes both stages
`timescale 1ns/1ps
`default_nettype none

module slvm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= '0;
            sync_out <= '0;
        end else if (ce) begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // slvm_sync

`default_nettype wire

// [hw/slvm_delay.sv]
// slvm_delay: one-cycle pulse once a level has stood high for a cycle count
// assumes: pclk domain level input, ce freezes the counter
`timescale 1ns/1ps
`default_nettype none

module slvm_delay #(
    parameter int CYCLES = 125,
    parameter int CW = $clog2(CYCLES + 1)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic level,
    output logic elapsed
);

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_elapsed;

    always_comb begin
        next_count = count;
        next_elapsed = 1'b0;
        if (!level) begin
            next_count = '0;
        end else if (count != CW'(CYCLES)) begin
            next_count = count + CW'(1);
            next_elapsed = (count == CW'(CYCLES - 1));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            elapsed <= 1'b0;
        end else if (ce) begin
            count <= next_count;
            elapsed <= next_elapsed;
        end
    end

endmodule // slvm_delay

`default_nettype wire

// [hw/slvm_top.sv]
// slvm_top: control and status logic of the supply low-voltage monitor
// assumes: apb master on pclk; comparator output is asynchronous;
// sleep, idle, reset-circuit enable and irq service come from pclk logic
//
// How it works
// (RULE1) codes 101, 110, 111 pick the low, middle and high threshold
// (RULE2) bit 5 reads 1 while supply is below threshold, else 0
// (RULE3) bit 4 switches the detector on or off
// (RULE4) bandgap on when detector, low-voltage reset or buffer bit enabled
// (RULE5) sleep forces the detector off whatever bit 4 says
// (RULE6) software waits for settling before trusting the status flag
// (RULE7) status flag follows the comparator continuously, may toggle
// (RULE8) irq flag sets only after the status has stood high a fixed delay
// (RULE9) a newly set irq flag wakes the device from idle, enable or not
// (RULE10) software sets irq flag first to avoid a low-voltage wake-up
// (RULE11) wake-up only on a low-to-high change of the irq flag
// (RULE12) servicing never clears the irq flag; software clears it
// (RULE13) vector taken only with global, irq and group enables all set
// (RULE14) bits 7 and 6 read zero, ignore writes; all bits reset to zero
// (RULE15) other threshold codes are reserved and leave the detector idle
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module slvm_top
    import slvm_pkg::*;
#(
    parameter int ADDR_WIDTH = 12,
    parameter int IRQ_DELAY_CYCLES = IRQ_ASSERT_DELAY_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comparator_below,
    input wire logic low_voltage_reset_enable,
    input wire logic sleep_mode,
    input wire logic idle_mode,
    input wire logic irq_service,
    output logic detector_on,
    output logic bandgap_enable,
    output logic [2:0] threshold_tap,
    output logic low_voltage_status_flag,
    output logic low_voltage_irq_flag,
    output logic vector_request,
    output logic wake_request
);

    // control register bits 4..0 and irq control bits
    logic detector_enable;
    logic bandgap_buffer_enable;
    logic [2:0] threshold_select;
    logic low_voltage_irq_enable;
    logic global_irq_enable;
    logic multifunction_group_enable;

    logic next_detector_enable;
    logic next_bandgap_buffer_enable;
    logic [2:0] next_threshold_select;
    logic next_low_voltage_irq_flag;
    logic next_low_voltage_irq_enable;
    logic next_global_irq_enable;
    logic next_multifunction_group_enable;

    // apb answer state
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // analogue-facing and event outputs
    logic next_detector_on;
    logic next_bandgap_enable;
    logic [2:0] next_threshold_tap;
    logic next_status_flag;
    logic next_vector_request;
    logic next_wake_request;

    logic comparator_sync;
    logic delay_elapsed;
    logic hit_control;
    logic hit_irq;
    logic access_done;
    logic write_low_byte;
    logic [2:0] tap_decode;
    logic [7:0] control_view;
    logic [7:0] irq_view;

    slvm_sync #(
        .WIDTH(1)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in(comparator_below),
        .sync_out(comparator_sync)
    );

    // status must stand high for the assert delay before the irq flag sets
    slvm_delay #(
        .CYCLES(IRQ_DELAY_CYCLES)
    ) u_delay (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .level(low_voltage_status_flag), // RULE8
        .elapsed(delay_elapsed)
    );

    // address decode
    assign hit_control = (paddr == ADDR_WIDTH'(ADDR_LOW_VOLTAGE_CONTROL));
    assign hit_irq = (paddr == ADDR_WIDTH'(ADDR_IRQ_CONTROL));
    assign access_done = psel && penable && pready;
    assign write_low_byte = access_done && pwrite && pstrb[0] && !pslverr;

    // threshold decode, reserved codes select nothing
    always_comb begin
        case (threshold_select)
            THRESHOLD_LOW: tap_decode = 3'h1 << TAP_LOW; // RULE1
            THRESHOLD_MID: tap_decode = 3'h1 << TAP_MID; // RULE1
            THRESHOLD_HIGH: tap_decode = 3'h1 << TAP_HIGH; // RULE1
            default: tap_decode = 3'h0; // RULE15
        endcase
    end

    // read views, bits 7 and 6 read zero
    always_comb begin
        control_view = 8'h00; // RULE14
        control_view[POS_STATUS_FLAG] = low_voltage_status_flag; // RULE2
        control_view[POS_DETECTOR_ENABLE] = detector_enable;
        control_view[POS_BANDGAP_BUFFER_ENABLE] = bandgap_buffer_enable;
        control_view[POS_THRESHOLD_SELECT +: THRESHOLD_SELECT_WIDTH] = threshold_select;
        irq_view = 8'h00;
        irq_view[POS_IRQ_FLAG] = low_voltage_irq_flag;
        irq_view[POS_IRQ_ENABLE] = low_voltage_irq_enable;
        irq_view[POS_GLOBAL_IRQ_ENABLE] = global_irq_enable;
        irq_view[POS_MULTIFUNCTION_GROUP_ENABLE] = multifunction_group_enable;
    end

    // apb slave: one wait cycle, answer registered
    always_comb begin
        next_pready = psel && penable && !pready;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        if (psel && penable && !pready) begin
            next_pslverr = !(hit_control || hit_irq);
            next_prdata = 32'h0000_0000;
            if (!pwrite && hit_control) begin
                next_prdata = {24'h00_0000, control_view};
            end else if (!pwrite && hit_irq) begin
                next_prdata = {24'h00_0000, irq_view};
            end
        end
    end

    // control register writes; bits 7, 6 and 5 of the write are dropped
    always_comb begin
        next_detector_enable = detector_enable;
        next_bandgap_buffer_enable = bandgap_buffer_enable;
        next_threshold_select = threshold_select;
        if (write_low_byte && hit_control) begin
            next_detector_enable = pwdata[POS_DETECTOR_ENABLE]; // RULE3
            next_bandgap_buffer_enable = pwdata[POS_BANDGAP_BUFFER_ENABLE];
            next_threshold_select =
                pwdata[POS_THRESHOLD_SELECT +: THRESHOLD_SELECT_WIDTH];
        end
    end

    // irq control: software may set or clear the flag, hardware set wins
    always_comb begin
        next_low_voltage_irq_flag = low_voltage_irq_flag;
        next_low_voltage_irq_enable = low_voltage_irq_enable;
        next_global_irq_enable = global_irq_enable;
        next_multifunction_group_enable = multifunction_group_enable;
        if (write_low_byte && hit_irq) begin
            next_low_voltage_irq_flag = pwdata[POS_IRQ_FLAG]; // RULE12
            next_low_voltage_irq_enable = pwdata[POS_IRQ_ENABLE];
            next_global_irq_enable = pwdata[POS_GLOBAL_IRQ_ENABLE];
            next_multifunction_group_enable = pwdata[POS_MULTIFUNCTION_GROUP_ENABLE];
        end
        // servicing drops only the global enable, never the flag
        if (irq_service) begin
            next_global_irq_enable = 1'b0; // RULE12
        end
        if (delay_elapsed) begin
            next_low_voltage_irq_flag = 1'b1; // RULE8
        end
    end

    // detector, bandgap, status and event outputs
    always_comb begin
        next_detector_on = detector_enable && !sleep_mode && (tap_decode != 3'h0); // RULE5
        next_threshold_tap = detector_enable ? tap_decode : 3'h0; // RULE1
        next_bandgap_enable = detector_enable || low_voltage_reset_enable // RULE4
            || bandgap_buffer_enable; // RULE4
        // flag tracks the comparator whenever the detector runs
        next_status_flag = detector_on && comparator_sync; // RULE7
        next_vector_request = low_voltage_irq_flag && low_voltage_irq_enable // RULE13
            && global_irq_enable && multifunction_group_enable; // RULE13
        // wake on a rising flag only, independent of enables
        next_wake_request = idle_mode && next_low_voltage_irq_flag // RULE9
            && !low_voltage_irq_flag; // RULE11
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            detector_enable <= RESET_CONTROL_BITS[POS_DETECTOR_ENABLE]; // RULE14
            bandgap_buffer_enable <= RESET_CONTROL_BITS[POS_BANDGAP_BUFFER_ENABLE];
            threshold_select <= RESET_CONTROL_BITS[2:0];
            low_voltage_irq_flag <= RESET_IRQ_BITS[POS_IRQ_FLAG];
            low_voltage_irq_enable <= RESET_IRQ_BITS[POS_IRQ_ENABLE];
            global_irq_enable <= RESET_IRQ_BITS[POS_GLOBAL_IRQ_ENABLE];
            multifunction_group_enable <= RESET_IRQ_BITS[POS_MULTIFUNCTION_GROUP_ENABLE];
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            detector_on <= 1'b0;
            bandgap_enable <= 1'b0;
            threshold_tap <= 3'h0;
            low_voltage_status_flag <= 1'b0;
            vector_request <= 1'b0;
            wake_request <= 1'b0;
        end else if (ce) begin
            detector_enable <= next_detector_enable;
            bandgap_buffer_enable <= next_bandgap_buffer_enable;
            threshold_select <= next_threshold_select;
            low_voltage_irq_flag <= next_low_voltage_irq_flag;
            low_voltage_irq_enable <= next_low_voltage_irq_enable;
            global_irq_enable <= next_global_irq_enable;
            multifunction_group_enable <= next_multifunction_group_enable;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            detector_on <= next_detector_on;
            bandgap_enable <= next_bandgap_enable;
            threshold_tap <= next_threshold_tap;
            low_voltage_status_flag <= next_status_flag; // RULE2
            vector_request <= next_vector_request;
            wake_request <= next_wake_request;
        end
    end

endmodule // slvm_top

`default_nettype wire

// [bench/slvm_monitor.sv]
// slvm_monitor: port-level checks of the low-voltage monitor
// assumes: bound into slvm_top, single pclk domain
`timescale 1ns/1ps
`default_nettype none

module slvm_monitor #(
    parameter int IRQ_DELAY_CYCLES = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic comparator_below,
    input wire logic low_voltage_reset_enable,
    input wire logic sleep_mode,
    input wire logic detector_on,
    input wire logic bandgap_enable,
    input wire logic [2:0] threshold_tap,
    input wire logic low_voltage_status_flag,
    input wire logic low_voltage_irq_flag,
    input wire logic vector_request,
    input wire logic wake_request
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);
    logic wr;
    logic [15:0] run, next_run;
    assign wr = psel & penable & pwrite;
    // consecutive cycles of status high
    always_comb begin
        next_run = low_voltage_status_flag ? run + 16'h1 : 16'h0;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) run <= 16'h0;
        else run <= next_run;
    end
    // only running cycles move the synchroniser and status register
    sequence s_below_held; (ce && detector_on && comparator_below) [*3]; endsequence
    sequence s_above_held; (ce && !comparator_below) [*3]; endsequence
    property p_tap; detector_on |-> $onehot(threshold_tap); endproperty
    property p_status_on; low_voltage_status_flag |-> $past(detector_on); endproperty
    property p_follow_hi; s_below_held |=> low_voltage_status_flag; endproperty
    property p_follow_lo; s_above_held |=> !low_voltage_status_flag; endproperty
    property p_lvr; low_voltage_reset_enable |=> bandgap_enable; endproperty
    property p_sleep; sleep_mode |=> !detector_on; endproperty
    property p_delay;
        $rose(low_voltage_irq_flag) && !$past(wr) |-> $past(run) >= IRQ_DELAY_CYCLES;
    endproperty
    property p_keep; low_voltage_irq_flag && !wr |=> low_voltage_irq_flag; endproperty
    property p_vector; vector_request |-> $past(low_voltage_irq_flag); endproperty
    property p_wake_edge;
        wake_request |-> low_voltage_irq_flag && !$past(low_voltage_irq_flag);
    endproperty
    property p_wake_pulse; wake_request |=> !wake_request; endproperty
    property p_read_zero; pready |-> prdata[31:6] == 26'h0; endproperty
    a_tap: assert property (p_tap) else $error("tap not one-hot");
    a_status_on: assert property (p_status_on) else $error("status while off");
    a_follow_hi: assert property (p_follow_hi) else $error("status not set");
    a_follow_lo: assert property (p_follow_lo) else $error("status not clear");
    a_lvr: assert property (p_lvr) else $error("bandgap off");
    a_sleep: assert property (p_sleep) else $error("detector on in sleep");
    a_delay: assert property (p_delay) else $error("irq flag early");
    a_keep: assert property (p_keep) else $error("irq flag dropped");
    a_vector: assert property (p_vector) else $error("vector without flag");
    a_wake_edge: assert property (p_wake_edge) else $error("wake w/o rise");
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
    a_read_zero: assert property (p_read_zero) else $error("upper bits set");
endmodule // slvm_monitor

bind slvm_top slvm_monitor #(.IRQ_DELAY_CYCLES(IRQ_DELAY_CYCLES)) slvm_monitor_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .comparator_below(comparator_below),
    .low_voltage_reset_enable(low_voltage_reset_enable), .sleep_mode(sleep_mode),
    .detector_on(detector_on), .bandgap_enable(bandgap_enable),
    .threshold_tap(threshold_tap), .low_voltage_status_flag(low_voltage_status_flag),
    .low_voltage_irq_flag(low_voltage_irq_flag), .vector_request(vector_request),
    .wake_request(wake_request));

`default_nettype wire

// [bench/tb_top.sv]
// tb_top: self-checking bench of slvm_top
// assumes: apb master here, irq delay shortened to 4 cycles
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import slvm_pkg::*;
;
    localparam logic [11:0] CTL = ADDR_LOW_VOLTAGE_CONTROL;
    localparam logic [11:0] IRQ = ADDR_IRQ_CONTROL;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic comparator_below = 0, low_voltage_reset_enable = 0, sleep_mode = 0;
    logic idle_mode = 0, irq_service = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hf;
    logic [2:0] threshold_tap;
    logic pready, pslverr, detector_on, bandgap_enable, low_voltage_status_flag;
    logic low_voltage_irq_flag, vector_request, wake_request;
    int failures = 0, num_checks = 0, cyc = 0;

    slvm_top #(.IRQ_DELAY_CYCLES(4)) slvm_top_i (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .comparator_below(comparator_below),
        .low_voltage_reset_enable(low_voltage_reset_enable), .sleep_mode(sleep_mode),
        .idle_mode(idle_mode), .irq_service(irq_service), .detector_on(detector_on),
        .bandgap_enable(bandgap_enable), .threshold_tap(threshold_tap),
        .low_voltage_status_flag(low_voltage_status_flag),
        .low_voltage_irq_flag(low_voltage_irq_flag), .vector_request(vector_request),
        .wake_request(wake_request));

    initial forever #4 pclk = ~pclk;

    task automatic complete_run;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // one transfer, then one idle edge before the next
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        repeat (2) @(posedge pclk);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic ex);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk("prdata", x, r);
        chk("pslverr", {31'h0, ex}, {31'h0, e});
    endtask

    task automatic watch(input int k, input int x);
        int n;
        n = 0;
        repeat (k) begin
            @(posedge pclk);
            if (wake_request === 1'b1) n++;
        end
        chk("wake count", x, n);
    endtask

    task automatic t_regs;
        rdc(CTL, 32'h0, 1'b0);
        rdc(IRQ, 32'h0, 1'b0);
        wr(CTL, 32'hff);
        rdc(CTL, 32'h1f, 1'b0);
        // byte lane off, then unmapped write: neither may land
        pstrb <= 4'h0;
        wr(CTL, 32'h00);
        pstrb <= 4'hf;
        wr(12'h008, 32'h00);
        rdc(CTL, 32'h1f, 1'b0);
        rdc(12'h008, 32'h0, 1'b1);
    endtask

    task automatic t_codes;
        for (int c = 0; c < 8; c++) begin
            wr(CTL, 32'h10 | c);
            chk("threshold_tap", (c > 4) ? 32'h1 << (c - 5) : 32'h0, threshold_tap);
            chk("detector_on", c > 4, detector_on);
            chk("bandgap_enable", 1, bandgap_enable);
        end
    endtask

    task automatic t_bandgap;
        wr(CTL, 32'h05);
        chk("bandgap_enable", 0, bandgap_enable);
        chk("detector_on", 0, detector_on);
        chk("threshold_tap", 0, threshold_tap);
        low_voltage_reset_enable <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("bandgap_enable", 1, bandgap_enable);
        low_voltage_reset_enable <= 1'b0;
        wr(CTL, 32'h08);
        chk("bandgap_enable", 1, bandgap_enable);
    endtask

    task automatic t_status;
        wr(CTL, 32'h15);
        repeat (4) @(posedge pclk);
        comparator_below <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("status", 1, low_voltage_status_flag);
        rdc(CTL, 32'h35, 1'b0);
        comparator_below <= 1'b0;
        repeat (5) @(posedge pclk);
        rdc(CTL, 32'h15, 1'b0);
        comparator_below <= 1'b1;
        sleep_mode <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("detector_on", 0, detector_on);
        chk("status", 0, low_voltage_status_flag);
        sleep_mode <= 1'b0;
        comparator_below <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask

    task automatic t_irq;
        wr(IRQ, 32'h0e);
        idle_mode <= 1'b1;
        comparator_below <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("irq flag", 0, low_voltage_irq_flag);
        watch(30, 1);
        chk("irq flag", 1, low_voltage_irq_flag);
        chk("vector", 1, vector_request);
        irq_service <= 1'b1;
        @(posedge pclk);
        irq_service <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("irq flag", 1, low_voltage_irq_flag);
        chk("vector", 0, vector_request);
        rdc(IRQ, 32'h0b, 1'b0);
        comparator_below <= 1'b0;
        repeat (5) @(posedge pclk);
        wr(IRQ, 32'h0);
        rdc(IRQ, 32'h0, 1'b0);
    endtask

    task automatic t_nowake;
        // flag goes high before idle is entered
        idle_mode <= 1'b0;
        wr(IRQ, 32'h01);
        idle_mode <= 1'b1;
        comparator_below <= 1'b1;
        watch(30, 0);
        chk("irq flag", 1, low_voltage_irq_flag);
        comparator_below <= 1'b0;
        idle_mode <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask

    task automatic t_freeze;
        wr(CTL, 32'h15);
        ce <= 1'b0;
        comparator_below <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("status", 0, low_voltage_status_flag);
        chk("detector_on", 1, detector_on);
        ce <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("status", 1, low_voltage_status_flag);
        comparator_below <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("status", 0, low_voltage_status_flag);
    endtask

    task automatic t_reset;
        wr(CTL, 32'h1f);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("detector_on", 0, detector_on);
        chk("bandgap_enable", 0, bandgap_enable);
        chk("threshold_tap", 0, threshold_tap);
        rdc(CTL, 32'h0, 1'b0);
        rdc(IRQ, 32'h0, 1'b0);
    endtask

    initial begin
        forever begin
            @(posedge pclk);
            cyc++;
            if (cyc > 20000) begin
                failures++;
                complete_run();
            end
        end
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_codes();
        t_bandgap();
        t_status();
        t_irq();
        t_nowake();
        t_freeze();
        t_reset();
        complete_run();
    end
endmodule // tb_top

`default_nettype wire
